// ===== core/fds_pkg.sv
// Constants for the fluorescent display scan driver: port addresses,
// control fields, reset codes and scan timing.
// Assumes a 4-bit CPU port bus with 5-bit port addresses.
package fds_pkg;

    // Port addresses seen by CPU in/out instructions
    localparam logic [4:0] ADDR_DIG_HI   = 5'h03;  // Digit port G12..G15
    localparam logic [4:0] ADDR_SEG_MID  = 5'h04;  // Segment port S4..S7
    localparam logic [4:0] ADDR_SEG_HI   = 5'h05;  // Segment port S8..S11
    localparam logic [4:0] ADDR_DIG_MID  = 5'h0a;  // Digit port G8..G11
    localparam logic [4:0] ADDR_DIG_LO   = 5'h0b;  // Digit port G4..G7
    localparam logic [4:0] ADDR_SEG_LO   = 5'h0c;  // Segment port S0..S3
    localparam logic [4:0] ADDR_CONTROL  = 5'h1a;  // Control (write) / status (read)
    localparam logic [4:0] ADDR_MODE     = 5'h1b;  // Mode setting (write)

    // Display control register fields
    localparam int CTL_SEL_LSB   = 0;
    localparam int CTL_BLANK_BIT = 2;
    localparam int CTL_KEY_BIT   = 3;

    // Setting selected for mode writes
    localparam logic [1:0] SEL_SEGMENTS = 2'h0;
    localparam logic [1:0] SEL_DIGITS   = 2'h1;
    localparam logic [1:0] SEL_DIMMER   = 2'h2;

    // Status register fields
    localparam int STS_BLANK_BIT   = 0;
    localparam int STS_KEY_BIT     = 1;
    localparam int STS_REQ_BIT     = 2;
    localparam int STS_RUN_BIT     = 3;

    // Values after reset
    localparam logic [1:0] RST_SEL       = 2'h0;
    localparam logic       RST_BLANK     = 1'b1;
    localparam logic [3:0] RST_SEG_CODE  = 4'h0;  // Eight segments
    localparam logic [3:0] RST_DIG_CODE  = 4'h7;  // Eight digits
    localparam logic [3:0] RST_DIM_CODE  = 4'hf;  // Full brightness

    // Segment code offset: code 0 means eight segments
    localparam logic [3:0] SEG_CODE_OFFSET = 4'h7;

    // Pin groups
    localparam int DEDICATED_PINS = 12;
    localparam int SHARED_PINS    = 4;
    localparam int MAX_LINES      = 16;
    localparam int TOTAL_SCAN     = DEDICATED_PINS * 2 + SHARED_PINS * 2 - SHARED_PINS;

    // Segment time unit in interval timer input clocks (2^3 of them)
    localparam int SEG_UNIT_TICKS = 8;
    // Least spacing of display transfer cycles, in instruction cycles
    localparam int XFER_SPACING   = 32;

    // Display data always comes from bank zero
    localparam logic DISPLAY_DATA_BANK = 1'b0;

    // Operating modes of the core
    localparam logic [1:0] PMODE_NORMAL = 2'h0;
    localparam logic [1:0] PMODE_SLOW   = 2'h1;
    localparam logic [1:0] PMODE_HOLD   = 2'h2;

endpackage : fds_pkg

// ===== core/fds_driver.sv
// Automatic dynamic-scan driver for a fluorescent display with 28 outputs.
// Assumes a CPU that inserts one stolen instruction cycle per transfer
// request, a timebase tick from the interval timer input clock, and
// synchronous inputs on clk.
//
// How it works
// - Twenty-eight outputs: 12 digit, 12 segment, 4 shared digit/segment.
// - Programmable n segments by m digits, n up to 12+i, m up to 16-i.
// - Mode writes go to the setting last chosen in the control register.
// - Control 0101B chooses digit count; 1000B enables key scan and starts.
// - Segment code 0000B means eight segments; digit code 0111B eight digits.
// - Thirteen to sixteen segments cut available digits to fifteen to twelve.
// - With sixteen segments digit scanning starts at the fifth digit line.
// - Shared pins become segment or digit from the segment count alone.
// - Each display bit maps to one segment; a 1 lights it.
// - A transfer request steals one instruction cycle to fetch segment data.
// - The transfer always reads bank zero whatever bank software selected.
// - Transfers happen only while the blank flag is clear.
// - Transfers come at most once per 32 instruction cycles.
// - Segment time is eight interval timer input clocks in either setup.
// - While the display runs, writes to segment ports are blocked.
// - With key scan enabled, the interval timer request sets the blank flag.
// - That blanking ignores the interrupt master enable.
// - Blanking lasts until software clears it; display resumes at next transfer.
// - While blanked, segment ports are read and written for key scanning.
// - Entering slow or hold blanks and drives shared pins to zero.
// - In low power, digit ports lose scan drive and show their latches.
// - Slow keeps segment values from before; hold clears segment latches, drives them zero.
// - A readable status register shows driver operation.
// - Digit port writes take effect while running, ORed with the digit scan drive.
`timescale 1ns/1ps
`default_nettype none

module fds_driver
    import fds_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [4:0]  io_addr,
    input  wire logic [3:0]  io_wdata,
    output logic      [3:0]  io_rdata,
    input  wire logic [3:0]  seg_hi_pin_in,
    input  wire logic        segment_clock_tick,
    input  wire logic        instr_cycle,
    input  wire logic        interval_timer_request,
    input  wire logic [1:0]  power_mode,
    output logic             xfer_req,
    input  wire logic        xfer_ack,
    output logic      [4:0]  dm_addr,
    input  wire logic [15:0] dm_rdata,
    output logic      [11:0] digit_out,
    output logic      [11:0] seg_out,
    output logic      [3:0]  shared_out,
    output logic             display_blank_flag
);

    typedef enum logic [1:0] {FDS_IDLE, FDS_WAIT, FDS_SHOW} fds_state_t;

    typedef struct packed {
        fds_state_t  st;
        logic [1:0]  sel;
        logic        blank;
        logic        key_scan_enable;
        logic [3:0]  seg_code;
        logic [3:0]  dig_code;
        logic [3:0]  dim_code;
        logic [3:0]  digit_idx;
        logic [2:0]  tick_cnt;
        logic [4:0]  space_cnt;
        logic [15:0] seg_data;
        logic        xfer_req;
        logic [11:0] seg_latch;
        logic [11:0] dig_latch;
        logic [11:0] seg_pins;
        logic [11:0] dig_pins;
        logic [3:0]  gs_pins;
        logic [1:0]  pmode_prev;
        logic [3:0]  rdata;
    } fds_regs_t;

    fds_regs_t s_reg;
    fds_regs_t s_next;

    logic [4:0]  seg_n;
    logic [4:0]  dig_req;
    logic [4:0]  dig_max;
    logic [4:0]  dig_n;
    logic [3:0]  dig_start;
    logic [3:0]  phys_digit;
    logic [3:0]  on_ticks;
    logic [3:0]  shared_is_seg;
    logic [11:0] seg_used;
    logic        running;
    logic        lit;
    logic        seg_port_ok;
    logic [3:0]  last_idx;

    // Port nibbles list digit lines high index first
    function automatic logic [3:0] rev4(input logic [3:0] v);
        rev4 = {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    // Geometry from the programmed codes
    assign seg_n     = {1'b0, s_reg.seg_code + SEG_CODE_OFFSET} + 5'd1;
    assign dig_req   = {1'b0, s_reg.dig_code} + 5'd1;
    assign dig_max   = (seg_n > 5'd12) ? (5'd28 - seg_n) : 5'd16;
    assign dig_n     = (dig_req > dig_max) ? dig_max : dig_req;
    assign dig_start = (seg_n > 5'd12) ? 4'(seg_n - 5'd12) : 4'h0;
    assign last_idx  = 4'(dig_n - 5'd1);
    assign phys_digit = dig_start + s_reg.digit_idx;
    assign on_ticks  = {1'b0, s_reg.dim_code[3:1]} + 4'h1;

    // Shared pin i is a segment when the count reaches 13+i; dedicated segments above the count stay dark
    always_comb
    begin
        for (int i = 0; i < SHARED_PINS; i++)
        begin
            shared_is_seg[i] = (seg_n > 5'(DEDICATED_PINS + i));
        end
        for (int k = 0; k < DEDICATED_PINS; k++)
        begin
            seg_used[k] = (seg_n > 5'(k));
        end
    end

    // Driver runs only when unblanked in normal operation
    assign running     = !s_reg.blank && (power_mode == PMODE_NORMAL);
    assign seg_port_ok = !running;
    assign lit         = running && (s_reg.st == FDS_SHOW) && ({1'b0, s_reg.tick_cnt} < on_ticks);

    // Next-state logic
    always_comb
    begin
        logic lp_entry;
        logic seg_wr;
        lp_entry = 1'b0;
        seg_wr   = 1'b0;
        s_next   = s_reg;
        lp_entry = (power_mode != PMODE_NORMAL) && (s_reg.pmode_prev == PMODE_NORMAL);
        s_next.pmode_prev = power_mode;

        // Control and mode writes
        if (io_wr && io_addr == ADDR_CONTROL)
        begin
            s_next.sel             = io_wdata[CTL_SEL_LSB +: 2];
            s_next.blank           = io_wdata[CTL_BLANK_BIT];
            s_next.key_scan_enable = io_wdata[CTL_KEY_BIT];
        end
        if (io_wr && io_addr == ADDR_MODE)
        begin
            case (s_reg.sel)
                SEL_SEGMENTS: s_next.seg_code = io_wdata;
                SEL_DIGITS:   s_next.dig_code = io_wdata;
                SEL_DIMMER:   s_next.dim_code = io_wdata;
                default:      s_next.dim_code = s_reg.dim_code;
            endcase
        end
        // Timer request blanks regardless of interrupt enable; set beats clear
        if (interval_timer_request && s_reg.key_scan_enable)
        begin
            s_next.blank = 1'b1;
        end
        if (lp_entry)
        begin
            s_next.blank = 1'b1;
        end

        // Segment ports: writable only while not displaying
        if (io_wr && seg_port_ok)
        begin
            case (io_addr)
                ADDR_SEG_LO:  begin s_next.seg_latch[3:0]  = io_wdata; seg_wr = 1'b1; end
                ADDR_SEG_MID: begin s_next.seg_latch[7:4]  = io_wdata; seg_wr = 1'b1; end
                ADDR_SEG_HI:  begin s_next.seg_latch[11:8] = io_wdata; seg_wr = 1'b1; end
                default:      seg_wr = 1'b0;
            endcase
        end
        // Digit ports always accept writes
        if (io_wr)
        begin
            case (io_addr)
                ADDR_DIG_LO:  s_next.dig_latch[3:0]  = rev4(io_wdata);
                ADDR_DIG_MID: s_next.dig_latch[7:4]  = rev4(io_wdata);
                ADDR_DIG_HI:  s_next.dig_latch[11:8] = rev4(io_wdata);
                default:      s_next.dig_latch = s_next.dig_latch;
            endcase
        end
        if (power_mode == PMODE_HOLD)
        begin
            s_next.seg_latch = '0;
        end

        // Transfer spacing counter
        if (instr_cycle && s_reg.space_cnt != 5'(XFER_SPACING - 1))
        begin
            s_next.space_cnt = s_reg.space_cnt + 5'd1;
        end

        // Scan sequencer
        if (!running)
        begin
            s_next.st        = FDS_IDLE;
            s_next.tick_cnt  = '0;
            s_next.digit_idx = '0;
            // A cycle granted as blanking starts still counts as spent
            if (s_reg.xfer_req && xfer_ack)
            begin
                s_next.space_cnt = '0;
            end
        end
        else
        begin
            case (s_reg.st)
                FDS_IDLE:
                    s_next.st = FDS_WAIT;
                FDS_WAIT:
                    if (s_reg.xfer_req && xfer_ack)
                    begin
                        s_next.seg_data  = dm_rdata;
                        s_next.space_cnt = '0;
                        s_next.st        = FDS_SHOW;
                    end
                FDS_SHOW:
                    if (segment_clock_tick)
                    begin
                        if (s_reg.tick_cnt == 3'(SEG_UNIT_TICKS - 1))
                        begin
                            s_next.tick_cnt  = '0;
                            s_next.digit_idx = (s_reg.digit_idx >= last_idx) ? 4'h0
                                               : s_reg.digit_idx + 4'h1;
                            s_next.st        = FDS_WAIT;
                        end
                        else
                        begin
                            s_next.tick_cnt = s_reg.tick_cnt + 3'd1;
                        end
                    end
                default:
                    s_next.st = FDS_IDLE;
            endcase
        end
        s_next.xfer_req = (s_next.st == FDS_WAIT) && !s_next.blank && (power_mode == PMODE_NORMAL)
                          && (s_next.space_cnt == 5'(XFER_SPACING - 1));

        // Dedicated digit pins: scan drive or latch
        for (int j = 0; j < DEDICATED_PINS; j++)
        begin
            s_next.dig_pins[j] = (lit && phys_digit == 4'(j + SHARED_PINS)) || s_reg.dig_latch[j];
        end
        // Shared pins follow the segment count
        for (int i = 0; i < SHARED_PINS; i++)
        begin
            if (power_mode != PMODE_NORMAL)
                s_next.gs_pins[i] = 1'b0;
            else if (shared_is_seg[i])
                s_next.gs_pins[i] = lit && s_reg.seg_data[DEDICATED_PINS + i];
            else
                s_next.gs_pins[i] = lit && (phys_digit == 4'(i));
        end
        // Segment pins
        case (power_mode)
            PMODE_HOLD:
                s_next.seg_pins = '0;
            PMODE_SLOW:
                s_next.seg_pins = seg_wr ? s_next.seg_latch : s_reg.seg_pins;
            default:
                s_next.seg_pins = lit ? (s_reg.seg_data[11:0] & seg_used)
                                  : (s_reg.blank ? s_reg.seg_latch : 12'h000);
        endcase

        // Registered read data
        if (io_rd)
        begin
            case (io_addr)
                ADDR_CONTROL: s_next.rdata = {running, s_reg.xfer_req,
                                              s_reg.key_scan_enable, s_reg.blank};
                ADDR_SEG_LO:  s_next.rdata = s_reg.seg_latch[3:0];
                ADDR_SEG_MID: s_next.rdata = s_reg.seg_latch[7:4];
                ADDR_SEG_HI:  s_next.rdata = seg_hi_pin_in;
                ADDR_DIG_LO:  s_next.rdata = rev4(s_reg.dig_latch[3:0]);
                ADDR_DIG_MID: s_next.rdata = rev4(s_reg.dig_latch[7:4]);
                ADDR_DIG_HI:  s_next.rdata = rev4(s_reg.dig_latch[11:8]);
                default:      s_next.rdata = 4'h0;
            endcase
        end
    end

    // State register with clock enable and synchronous reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_reg                 <= '0;
            s_reg.st              <= FDS_IDLE;
            s_reg.sel             <= RST_SEL;
            s_reg.blank           <= RST_BLANK;
            s_reg.seg_code        <= RST_SEG_CODE;
            s_reg.dig_code        <= RST_DIG_CODE;
            s_reg.dim_code        <= RST_DIM_CODE;
            s_reg.pmode_prev      <= PMODE_NORMAL;
        end
        else if (ce)
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign io_rdata           = s_reg.rdata;
    assign xfer_req           = s_reg.xfer_req;
    assign dm_addr            = {DISPLAY_DATA_BANK, s_reg.digit_idx};
    assign digit_out          = s_reg.dig_pins;
    assign seg_out            = s_reg.seg_pins;
    assign shared_out         = s_reg.gs_pins;
    assign display_blank_flag = s_reg.blank;

    // Checks
    chk_bank_zero: assert property (@(posedge clk) disable iff (!rst_n)
        xfer_req |-> dm_addr[4] == 1'b0)
        else $error("display fetch left bank zero");

    chk_req_unblanked: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.xfer_req |-> !s_reg.blank)
        else $error("transfer requested while blanked");

    chk_timer_blank: assert property (@(posedge clk) disable iff (!rst_n)
        ce && interval_timer_request && s_reg.key_scan_enable |=> s_reg.blank)
        else $error("timer request did not blank");

    chk_xfer_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        ce && s_reg.xfer_req && xfer_ack |=> !s_reg.xfer_req && s_reg.space_cnt == 5'd0)
        else $error("transfer spacing not restarted");

    chk_seg_blocked: assert property (@(posedge clk) disable iff (!rst_n)
        ce && io_wr && io_addr == ADDR_SEG_LO && running |=> $stable(s_reg.seg_latch))
        else $error("segment port written while displaying");

    chk_lowpower_shared: assert property (@(posedge clk) disable iff (!rst_n)
        ce && power_mode != PMODE_NORMAL |=> shared_out == 4'h0 && s_reg.blank)
        else $error("shared pins driven in low power");

    chk_digit_limit: assert property (@(posedge clk) disable iff (!rst_n)
        (dig_n + {1'b0, dig_start}) <= 5'd16)
        else $error("digit count exceeds free lines");

    chk_select_digits: assert property (@(posedge clk) disable iff (!rst_n)
        ce && io_wr && io_addr == ADDR_CONTROL && io_wdata == 4'h5
        |=> s_reg.sel == SEL_DIGITS && s_reg.blank)
        else $error("digit setting not selected");

    chk_one_digit: assert property (@(posedge clk) disable iff (!rst_n)
        s_reg.dig_latch == 12'h000 |-> $onehot0({s_reg.dig_pins, s_reg.gs_pins & ~shared_is_seg}))
        else $error("more than one digit lit");

    chk_hold_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ce && power_mode == PMODE_HOLD |=> s_reg.seg_latch == 12'h000 && seg_out == 12'h000)
        else $error("segment latch kept in hold");

    chk_unused_segs: assert property (@(posedge clk) disable iff (!rst_n)
        ce && lit |=> (seg_out & ~$past(seg_used)) == 12'h000)
        else $error("segment beyond count lit");

    chk_segment_time: assert property (@(posedge clk) disable iff (!rst_n)
        ce && running && s_reg.st == FDS_SHOW && segment_clock_tick
        && s_reg.tick_cnt == 3'(SEG_UNIT_TICKS - 1)
        |=> s_reg.st == FDS_WAIT && s_reg.tick_cnt == 3'h0)
        else $error("segment time not eight ticks");

    chk_dim_dark: assert property (@(posedge clk) disable iff (!rst_n)
        ce && running && s_reg.st == FDS_SHOW && {1'b0, s_reg.tick_cnt} >= on_ticks
        |=> seg_out == 12'h000 && shared_out == 4'h0)
        else $error("dimmed digit still lit");

endmodule : fds_driver

`default_nettype wire

// ===== tb/fds_key_panel.sv
// Key switch matrix hanging on the segment strobe pins.
// Assumes strobes on S0..S3, returns on S8..S11 with pull-downs.
`timescale 1ns/1ps
`default_nettype none

module fds_key_panel
    import fds_pkg::*;
(
    input  wire logic [11:0] seg_out,
    input  wire logic [11:0] digit_out,
    output logic      [3:0]  seg_hi_pin_in
);
    // One closed key joins strobe S0 to return S10
    localparam logic [3:0] KEY_RETURN = 4'h4;

    // Returns sit at the pull-down level unless a strobed key closes
    always_comb
    begin
        seg_hi_pin_in = 4'h0;
        if (seg_out[0] && digit_out == 12'h0)
            seg_hi_pin_in = KEY_RETURN;
    end
endmodule : fds_key_panel
`default_nettype wire

// ===== tb/tb_top.sv
// Testbench for the display scan driver: port bus tasks and scan checks.
// Assumes the key panel model on the pins and auto-granted transfer cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

module tb_top
    import fds_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, xfer_ack = 1'b0, tick_en = 1'b0;
    logic        instr_cycle = 1'b0, segment_clock_tick = 1'b0, interval_timer_request = 1'b0;
    logic [1:0]  power_mode = PMODE_NORMAL;
    logic [4:0]  io_addr = 5'h00, dm_addr;
    logic [3:0]  io_wdata = 4'h0, rdv, io_rdata, seg_hi_pin_in, shared_out;
    logic [15:0] dm_rdata = 16'h0000;
    logic [11:0] held, digit_out, seg_out;
    logic        xfer_req, display_blank_flag;
    int          mismatches = 0, comparisons = 0, cycles = 0, gap = 1000, takes = 0, t0;

    fds_driver u_fds_driver (
        .clk, .rst_n, .ce(1'b1), .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata, .seg_hi_pin_in,
        .segment_clock_tick, .instr_cycle, .interval_timer_request, .power_mode, .xfer_req, .xfer_ack,
        .dm_addr, .dm_rdata, .digit_out, .seg_out, .shared_out, .display_blank_flag
    );
    fds_key_panel u_fds_key_panel (.seg_out, .digit_out, .seg_hi_pin_in);

    // Clock at 50 ns
    initial
    begin
        forever #25 clk = ~clk;
    end

    // Display bits of one digit line
    function automatic logic [15:0] pat(input logic [3:0] i);
        return {4'h9, i, 4'h6, i};
    endfunction : pat

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [3:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        @(posedge clk);
        #1 d = io_rdata;
    endtask : rd

    // Waits for one transfer and checks the lit digit and segments
    task automatic xfer(input int want, input logic wide, input int on, output int got);
        logic [15:0] p;
        logic [15:0] eg;
        int          n;
        n = 0;
        @(posedge clk);
        #1;
        while (xfer_req !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("transfer request", 1'b1, xfer_req)
        `CHK("display bank", DISPLAY_DATA_BANK, dm_addr[4])
        got = (want < 0) ? int'(dm_addr[3:0]) : want;
        `CHK("digit index", got[3:0], dm_addr[3:0])
        p = pat(dm_addr[3:0]);
        eg = wide ? {12'h1 << got[3:0], p[15:12]} : 16'h1 << got[3:0];
        repeat (2) @(posedge clk);
        #1;
        `CHK("request drop", 1'b0, xfer_req)
        repeat (2) @(posedge clk);
        #1;
        `CHK("digit pins", eg, {digit_out, shared_out})
        `CHK("segment pins", wide ? p[11:0] : {4'h0, p[7:0]}, seg_out)
        // Lit for on ticks of the segment time, then dark
        if (on > 0)
        begin
            repeat (on - 2) @(posedge clk);
            #1;
            `CHK("digit pins late", eg, {digit_out, shared_out})
            @(posedge clk);
            #1;
            `CHK("dimmed pins", 28'h0, {digit_out, seg_out, shared_out})
        end
    endtask : xfer

    task automatic scan(input int n, input int m, input logic wide, input int on);
        int g;
        xfer(-1, wide, on, g);
        repeat (n) xfer((g + 1) % m, wide, on, g);
    endtask : scan

    // CPU side: grants stolen cycles, serves display bits, runs the timebase
    always @(posedge clk)
    begin
        cycles             <= cycles + 1;
        xfer_ack           <= xfer_req & ~xfer_ack;
        dm_rdata           <= pat(dm_addr[3:0]);
        instr_cycle        <= tick_en;
        segment_clock_tick <= tick_en;
        gap                <= gap + 1;
        if (xfer_req && xfer_ack)
        begin
            takes <= takes + 1;
            gap   <= 0;
            if (gap < 1000)
                `CHK("transfer spacing", 1'b1, gap + 1 >= XFER_SPACING)
        end
        if (cycles == 6000)
        begin
            mismatches++;
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_CONTROL, rdv);
        `CHK("status after reset", 4'h1, rdv)
        `CHK("pins after reset", 28'h0, {digit_out, seg_out, shared_out})
        wr(ADDR_MODE, 4'h0);
        wr(ADDR_CONTROL, 4'h5);
        wr(ADDR_MODE, 4'h7);
        wr(ADDR_CONTROL, 4'h8);
        rd(ADDR_CONTROL, rdv);
        `CHK("status running", 4'ha, rdv)
        tick_en <= 1'b1;
        scan(8, 8, 1'b0, 8);
        wr(ADDR_SEG_LO, 4'hf);
        wr(ADDR_DIG_LO, 4'h8);
        @(posedge clk);
        #1 `CHK("digit port write", 1'b1, digit_out[0])
        wr(ADDR_DIG_LO, 4'h0);
        // Timer request blanks the display for key scanning
        @(posedge clk);
        interval_timer_request <= 1'b1;
        @(posedge clk);
        interval_timer_request <= 1'b0;
        @(posedge clk);
        #1 `CHK("blank on timer", 1'b1, display_blank_flag)
        rd(ADDR_CONTROL, rdv);
        `CHK("status blanked", 4'h3, rdv)
        t0 = takes;
        repeat (80) @(posedge clk);
        `CHK("no transfer while blank", t0, takes)
        rd(ADDR_SEG_LO, rdv);
        `CHK("refused segment write", 4'h0, rdv)
        wr(ADDR_SEG_LO, 4'h5);
        rd(ADDR_SEG_LO, rdv);
        `CHK("segment latch", 4'h5, rdv)
        `CHK("strobe pins", 4'h5, seg_out[3:0])
        rd(ADDR_SEG_HI, rdv);
        `CHK("key return", 4'h4, rdv)
        // Sixteen segments, sixteen digits asked, twelve scanned
        wr(ADDR_SEG_LO, 4'h0);
        wr(ADDR_CONTROL, 4'h4);
        wr(ADDR_MODE, 4'h8);
        wr(ADDR_CONTROL, 4'h5);
        wr(ADDR_MODE, 4'hf);
        wr(ADDR_CONTROL, 4'h6);
        wr(ADDR_MODE, 4'h7);
        wr(ADDR_CONTROL, 4'h0);
        scan(13, 12, 1'b1, 4);
        // Low power entry from a lit digit
        xfer(-1, 1'b1, 0, t0);
        held = seg_out;
        @(posedge clk);
        power_mode <= PMODE_SLOW;
        repeat (3) @(posedge clk);
        #1;
        `CHK("blank in slow", 1'b1, display_blank_flag)
        `CHK("shared pins in slow", 4'h0, shared_out)
        `CHK("digit pins in slow", 12'h0, digit_out)
        `CHK("segments held in slow", held, seg_out)
        @(posedge clk);
        power_mode <= PMODE_HOLD;
        repeat (3) @(posedge clk);
        #1;
        `CHK("segments in hold", 12'h0, seg_out)
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
